// File: hdl/xordp_cfg.svh
// Purpose: constants for the xor instruction datapath
// Assumes: 16-bit instruction words, 8-bit data
// Notes:   opcode patterns compared against instruction bits 15:9 / 15:8
`ifndef XORDP_CFG_SVH
`define XORDP_CFG_SVH
`define XORDP_LIT_OPC      8'hb4
`define XORDP_FILE_OPC     7'h06
`define XORDP_TGT_BIT      8
`define XORDP_WORK_RST     8'h00
`define XORDP_RF_RST       8'h00
`define XORDP_NULL_RST     1'b0
`endif

// File: hdl/xordp_pkg.sv
// Purpose: shared types for the xor instruction datapath
// Assumes: four quarter phases per instruction cycle
// Notes:   phase codes are gray along q1..q4
package xordp_pkg;
   typedef enum logic [1:0] {
      XORDP_Q1 = 2'b00,
      XORDP_Q2 = 2'b01,
      XORDP_Q3 = 2'b11,
      XORDP_Q4 = 2'b10
   } xordp_phase_e;
   typedef logic [7:0]  xordp_byte_t;
   typedef logic [15:0] xordp_word_t;
endpackage : xordp_pkg

// File: hdl/xordp_rf_if.sv
// Purpose: register file access bundle between datapath modules
// Assumes: single clock domain
// Notes:   one address shared by the read and the write path
`timescale 1ns/1ps
`default_nettype none
interface xordp_rf_if;
   import xordp_pkg::*;
   xordp_byte_t addr;
   xordp_byte_t rdData;
   xordp_byte_t wrData;
   logic        wrEn;
   modport core (output addr, input rdData, output wrData, output wrEn);
   modport file (input addr, output rdData, input wrData, input wrEn);
endinterface : xordp_rf_if
`default_nettype wire

// File: hdl/xordp_regfile.sv
// Purpose: 256 byte data register file for the xor datapath
// Assumes: combinational read, write on clock edge
// Notes:   contents cleared by reset so no xor ever folds in an unknown byte
`timescale 1ns/1ps
`default_nettype none
`include "xordp_cfg.svh"
module xordp_regfile (
   input  wire logic clk,
   input  wire logic nrst,
   xordp_rf_if.file  rf
);
   import xordp_pkg::*;
   xordp_byte_t mem [0:255];
   // asynchronous read so operands are ready in q2
   assign rf.rdData = mem[rf.addr];
   // write only when the core asks, in q4; reset costs flops but keeps results known
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 256; i++) begin
            mem[i] <= `XORDP_RF_RST;
         end
      end else if (rf.wrEn) begin
         mem[rf.addr] <= rf.wrData;
      end
   end
endmodule : xordp_regfile
`default_nettype wire

// File: hdl/xordp_core.sv
// Purpose: executes the literal and file xor instructions of an 8-bit core
// Assumes: instruction word is held stable on instr for the whole cycle
// Notes:   one instruction cycle is four clocks, q1 to q4
`timescale 1ns/1ps
`default_nettype none
`include "xordp_cfg.svh"
// Operation
// - literal xor: working register xor low instruction byte into working register
// - file xor: working register xor addressed data register, bit 8 selects target
// - target clear: result to working register, data register untouched
// - target set: result to data register, working register untouched
// - one word, one cycle: decode q1, read q2, execute q3, write q4
module xordp_core (
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire xordp_pkg::xordp_word_t instr,
   input  wire logic                instrValid,
   input  wire logic                rfPeekEn,
   input  wire xordp_pkg::xordp_byte_t rfPeekAddr,
   output logic                     cycleStart,
   output xordp_pkg::xordp_byte_t   rfPeekData,
   output xordp_pkg::xordp_byte_t   workingRegister,
   output logic                     resultNullFlag
);
   import xordp_pkg::*;

   xordp_rf_if rf ();

   // sequencer state
   xordp_phase_e phase_r, phase_nxt;

   // decode state, latched at the q1 edge
   logic         isLit_r, isLit_nxt;
   logic         isFile_r, isFile_nxt;
   logic         tgt_r, tgt_nxt;
   xordp_byte_t  lit_r, lit_nxt;
   xordp_byte_t  addr_r, addr_nxt;

   // operand and result, moved in q2 and q3
   xordp_byte_t  opnd_r, opnd_nxt;
   xordp_byte_t  res_r, res_nxt;

   // visible state, moved only at the q4 edge
   xordp_byte_t  workReg_r, workReg_nxt;
   logic         null_r, null_nxt;

   // observation path into the data registers
   xordp_byte_t  peek_r, peek_nxt;

   // decode helpers, used only by the decode group at the q1 edge
   function automatic logic isLitOp(input xordp_word_t w);
      return w[15:8] == `XORDP_LIT_OPC;
   endfunction : isLitOp

   function automatic logic isFileOp(input xordp_word_t w);
      return w[15:9] == `XORDP_FILE_OPC;
   endfunction : isFileOp

   // destination decode, kept apart so the two write strobes never overlap
   function automatic logic toWork(input logic lit, input logic fil, input logic tgt);
      return lit || (fil && !tgt);
   endfunction : toWork

   function automatic logic toFile(input logic fil, input logic tgt);
      return fil && tgt;
   endfunction : toFile

   // zero test of a result byte for the null flag
   function automatic logic isZero(input xordp_byte_t b);
      return b == 8'h00;
   endfunction : isZero

   // phase sequencer: free running four phase cycle
   always_comb begin
      case (phase_r)
         XORDP_Q1: phase_nxt = XORDP_Q2;
         XORDP_Q2: phase_nxt = XORDP_Q3;
         XORDP_Q3: phase_nxt = XORDP_Q4;
         XORDP_Q4: phase_nxt = XORDP_Q1;
         default:  phase_nxt = XORDP_Q1;
      endcase
   end

   // decode group: kind, target and operand byte are taken at the q1 edge
   always_comb begin
      isLit_nxt  = isLit_r;
      isFile_nxt = isFile_r;
      tgt_nxt    = tgt_r;
      lit_nxt    = lit_r;
      addr_nxt   = addr_r;
      case (phase_r)
         XORDP_Q1: begin
            // unknown opcodes decode to neither kind, so no visible state or data register moves later
            isLit_nxt  = instrValid && isLitOp(instr);
            isFile_nxt = instrValid && isFileOp(instr);
            tgt_nxt    = instr[`XORDP_TGT_BIT];
            lit_nxt    = instr[7:0];
            addr_nxt   = instr[7:0]; // full 0..255 range
         end
         XORDP_Q2, XORDP_Q3, XORDP_Q4: begin
            // decoded fields stand for the rest of the cycle
            tgt_nxt = tgt_r;
         end
         default: begin
            isLit_nxt  = 1'b0;
            isFile_nxt = 1'b0;
         end
      endcase
   end

   // operand group: fetch in q2, xor in q3
   always_comb begin
      opnd_nxt = opnd_r;
      res_nxt  = res_r;
      case (phase_r)
         XORDP_Q2: begin
            // the port is steered to the decoded address in q2
            opnd_nxt = isLit_r ? lit_r : rf.rdData;
         end
         XORDP_Q3: begin
            res_nxt = workReg_r ^ opnd_r;
         end
         XORDP_Q1, XORDP_Q4: begin
            // result stands through q4 so the write-back sees a settled byte
            res_nxt = res_r;
         end
         default: begin
            opnd_nxt = 8'h00;
         end
      endcase
   end

   // write-back group: only the q4 edge moves the visible state
   always_comb begin
      workReg_nxt = workReg_r;
      null_nxt    = null_r;
      if (phase_r == XORDP_Q4) begin
         if (toWork(isLit_r, isFile_r, tgt_r)) begin
            workReg_nxt = res_r;
         end
         if (isLit_r || isFile_r) begin
            null_nxt = isZero(res_r);
         end
      end
   end

   // peek reads only in q1 and q3 so the operand fetch and the write-back keep the port
   always_comb begin
      peek_nxt = peek_r;
      if (rfPeekEn && phase_r != XORDP_Q2 && phase_r != XORDP_Q4) begin
         peek_nxt = rf.rdData;
      end
   end

   // register file port: write only the target-set file op in q4
   always_comb begin
      rf.wrEn   = (phase_r == XORDP_Q4) && toFile(isFile_r, tgt_r);
      rf.wrData = res_r;
      // the peek address borrows the port only in q1 and q3
      if (phase_r == XORDP_Q2 || phase_r == XORDP_Q4) begin
         rf.addr = addr_r;
      end else begin
         rf.addr = rfPeekAddr;
      end
   end

   // phase register; reset parks it in q1 so the first edge decodes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_r <= XORDP_Q1;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // decode registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         isLit_r  <= 1'b0;
         isFile_r <= 1'b0;
         tgt_r    <= 1'b0;
         lit_r    <= 8'h00;
         addr_r   <= 8'h00;
      end else begin
         isLit_r  <= isLit_nxt;
         isFile_r <= isFile_nxt;
         tgt_r    <= tgt_nxt;
         lit_r    <= lit_nxt;
         addr_r   <= addr_nxt;
      end
   end

   // operand and result registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         opnd_r <= 8'h00;
         res_r  <= 8'h00;
      end else begin
         opnd_r <= opnd_nxt;
         res_r  <= res_nxt;
      end
   end

   // visible state; cleared so the first xor starts from a known byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         workReg_r <= `XORDP_WORK_RST;
         null_r    <= `XORDP_NULL_RST;
      end else begin
         workReg_r <= workReg_nxt;
         null_r    <= null_nxt;
      end
   end

   // peek register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         peek_r <= 8'h00;
      end else begin
         peek_r <= peek_nxt;
      end
   end

   xordp_regfile u_regfile (
      .clk  (clk),
      .nrst (nrst),
      .rf   (rf.file)
   );

   assign cycleStart      = (phase_r == XORDP_Q1);
   assign rfPeekData      = peek_r;
   assign workingRegister = workReg_r;
   assign resultNullFlag  = null_r;
endmodule : xordp_core
`default_nettype wire

// File: dv/xordp_core_sva.sv
// Purpose: port checks for xordp_core
// Assumes: four clocks per cycle
// Notes:   results show after q4
`timescale 1ns/1ps
`default_nettype none
module xordp_core_sva (
   input wire logic                   clk,
   input wire logic                   nrst,
   input wire xordp_pkg::xordp_word_t instr,
   input wire logic                   instrValid,
   input wire logic                   cycleStart,
   input wire xordp_pkg::xordp_byte_t workingRegister,
   input wire logic                   resultNullFlag
);
   import xordp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // file op taken on a q1 edge
   sequence fileGo; cycleStart && instrValid && instr[15:9] == 7'h06; endsequence
   chk_lit_xor: assert property (cycleStart && instrValid && instr[15:8] == 8'hb4 |->
      ##4 workingRegister === ($past(workingRegister, 4) ^ $past(instr[7:0], 4)))
      else $error("bad xor");
   chk_file_keep: assert property (fileGo ##0 instr[8] |->
      ##4 workingRegister === $past(workingRegister, 4)) else $error("work reg hit");
   chk_file_null: assert property (fileGo ##0 !instr[8] |-> ##4
      resultNullFlag === (workingRegister == 8'h00)) else $error("bad file flag");
   chk_four_clk: assert property (cycleStart |=> !cycleStart [*3] ##1 cycleStart)
      else $error("bad cycle");
   chk_mid_hold: assert property (!cycleStart |->
      workingRegister === $past(workingRegister)) else $error("moved mid cycle");
   chk_null_track: assert property (workingRegister !== $past(workingRegister) |->
      resultNullFlag === (workingRegister == 8'h00)) else $error("bad null flag");
endmodule : xordp_core_sva
bind xordp_core xordp_core_sva u_sva (.clk(clk), .nrst(nrst), .instr(instr),
   .instrValid(instrValid), .cycleStart(cycleStart),
   .workingRegister(workingRegister), .resultNullFlag(resultNullFlag));
`default_nettype wire

// File: dv/xordp_core_tb_top.sv
// Purpose: directed bench for xordp_core
// Assumes: data regs clear to zero on reset
// Notes:   file results judged by peek
`timescale 1ns/1ps
`default_nettype none
module xordp_core_tb_top;
   import xordp_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, vld = 1'b0, pkEn = 1'b0, cs, nul;
   xordp_word_t ins = 16'h0000;
   xordp_byte_t pkA = 8'hff, pkD, wrk;
   int          errors = 0, checks = 0;
   always #2.5 clk = ~clk; // 200 MHz
   xordp_core dut (.clk(clk), .nrst(nrst), .instr(ins), .instrValid(vld),
      .rfPeekEn(pkEn), .rfPeekAddr(pkA), .cycleStart(cs), .rfPeekData(pkD),
      .workingRegister(wrk), .resultNullFlag(nul));
   task automatic chk(string n, xordp_byte_t s, xordp_byte_t e);
      checks++;
      errors += int'(s !== e);
      if (s !== e) $display("BAD %s exp %h got %h", n, e, s);
   endtask : chk
   task automatic summarize;
      if (errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   // valid is left up so back to back words need no gap
   task automatic op(xordp_word_t i, logic v);
      for (int n = 0; n < 4 && cs !== 1'b1; n++) @(posedge clk) #1;
      ins = i;
      vld = v;
      repeat (4) @(posedge clk);
      #1;
   endtask : op
   // peek works in q1 and q3, this task uses q1, data one edge later
   task automatic peek(output xordp_byte_t d);
      for (int n = 0; n < 4 && cs !== 1'b1; n++) @(posedge clk) #1;
      vld = 1'b0;
      pkEn = 1'b1;
      @(posedge clk) #1;
      pkEn = 1'b0;
      d = pkD;
   endtask : peek
   // back to back literals, then foreign codes and an idle slot
   task automatic t_lit;
      op(16'hb4af, 1'b1);
      chk("wrk", wrk, 8'haf);
      op(16'hb4af, 1'b1);
      chk("nul", {7'h00, nul}, 8'h01);
      op(16'hb455, 1'b1);
      chk("nul lit", {7'h00, nul}, 8'h00);
      op(16'hb5af, 1'b1);
      op(16'h0eff, 1'b1);
      op(16'hb4ff, 1'b0);
      chk("wrk noop", wrk, 8'h55);
   endtask : t_lit
   // top address: result to data reg, then to work reg
   task automatic t_file;
      xordp_byte_t p, q;
      peek(p);
      chk("reg init", p, 8'h00);
      op(16'h0dff, 1'b1);
      chk("wrk d1", wrk, 8'h55);
      chk("nul d1", {7'h00, nul}, 8'h00);
      peek(q);
      chk("reg d1", q, 8'h55);
      op(16'h0cff, 1'b1);
      chk("wrk d0", wrk, 8'h00);
      chk("nul d0", {7'h00, nul}, 8'h01);
      peek(q);
      chk("reg d0", q, 8'h55);
   endtask : t_file
   // reset, then the scenarios
   initial begin
      repeat (5) @(posedge clk);
      #1 nrst = 1'b1;
      t_lit();
      t_file();
      summarize();
   end
   // hang guard, tests need about 50 clocks
   initial begin
      #5000;
      errors++;
      summarize();
   end
endmodule : xordp_core_tb_top
`default_nettype wire
